// ---- rtl/pms_pkg.sv ----
// Constants shared by the power module status and sequencing register bank.
package pms_pkg;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int STR_N = 6;
  // Command codes.
  localparam logic [7:0] CMD_UV_LIMIT = 8'h59;
  localparam logic [7:0] CMD_UV_ACTION = 8'h5a;
  localparam logic [7:0] CMD_PG_THRESH = 8'h5e;
  localparam logic [7:0] CMD_TON_WAIT = 8'h60;
  localparam logic [7:0] CMD_TON_RAMP = 8'h61;
  localparam logic [7:0] CMD_TOFF_WAIT = 8'h64;
  localparam logic [7:0] CMD_TOFF_RAMP = 8'h65;
  localparam logic [7:0] CMD_SUM_LOW = 8'h78;
  localparam logic [7:0] CMD_SUM_FULL = 8'h79;
  localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7a;
  localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7b;
  localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7c;
  localparam logic [7:0] CMD_TEMP_FLAGS = 8'h7d;
  localparam logic [7:0] CMD_CML_FLAGS = 8'h7e;
  localparam logic [7:0] CMD_VENDOR_FLAGS = 8'h80;
  localparam logic [7:0] CMD_VIN_READ = 8'h88;
  localparam logic [7:0] CMD_VOUT_READ = 8'h8b;
  localparam logic [7:0] CMD_IOUT_READ = 8'h8c;
  localparam logic [7:0] CMD_TINT_READ = 8'h8d;
  localparam logic [7:0] CMD_TEXT_READ = 8'h8f;
  localparam logic [7:0] CMD_DUTY_READ = 8'h94;
  localparam logic [7:0] CMD_FREQ_READ = 8'h95;
  localparam logic [7:0] CMD_PROTO_REV = 8'h98;
  localparam logic [7:0] CMD_MAKER_STR = 8'h99;
  localparam logic [7:0] CMD_UREV_STR = 8'h9b;
  localparam logic [7:0] CMD_ULOC_STR = 8'h9c;
  localparam logic [7:0] CMD_UDATE_STR = 8'h9d;
  localparam logic [7:0] CMD_SERIAL_STR = 8'h9e;
  localparam logic [7:0] CMD_SCRATCH_STR = 8'hb0;
  localparam logic [7:0] CMD_USER_CFG = 8'hd1;
  // Values after reset, and fixed read values.
  localparam logic [7:0] RST_UV_ACTION = 8'hbf;
  localparam logic [15:0] RST_TIMING = 16'hca80;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] PROTO_REV_VALUE = 8'h22;
  localparam logic [15:0] UNMAPPED_READ = 16'hffff;
  localparam logic [7:0] PAST_END_BYTE = 8'hff;
  // Summary word bit positions.
  localparam int SUM_CML_BIT = 1;
  localparam int SUM_TEMP_BIT = 2;
  localparam int SUM_INPUT_BIT = 3;
  localparam int SUM_IOUT_BIT = 4;
  localparam int SUM_VOUT_BIT = 5;
  localparam int SUM_VENDOR_BIT = 12;
  localparam int SUM_INPUTW_BIT = 13;
  localparam int SUM_IOUTW_BIT = 14;
  localparam int SUM_VOUTW_BIT = 15;
  // Communication flag bit positions.
  localparam int CML_BAD_CMD_BIT = 7;
  localparam int CML_BAD_DATA_BIT = 6;
  // Power-good default is nine tenths of the setpoint strap.
  localparam int PG_NUM = 9;
  localparam int PG_DEN = 10;
  // Clock cycles after reset release before straps are captured; then link bit counts and the length cap.
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [1:0] WLEN_MAX = 2'h3;
endpackage

// ---- rtl/pms_regs.sv ----
// Status and sequencing register bank behind a two-wire management link.
//
// Summary of operation
// - Undervoltage threshold is read-write, loaded from the lockout strap.
// - Undervoltage fault action is one byte, resetting to bfh.
// - Power-good threshold is read-write, default 0.9 of setpoint strap.
// - Turn-on wait is two bytes, resets to ca80h.
// - Output ramp-up time is two bytes, resetting to ca80h.
// - Turn-off wait is two bytes, resetting to ca80h.
// - Output ramp-down time is two bytes, resetting to ca80h.
// - Summary byte equals summary word low byte, zero without faults.
// - Summary word collects critical faults, reads zero without faults.
// - Separate category flag registers for vout, iout, input, temperature.
// - Communication, memory and logic flags register resets to zero.
// - Vendor flags report monitor and clock sync faults, reset to zero.
// - Input voltage and output current readings are returned read-only.
// - Output voltage reading is returned read-only.
// - Internal and external temperature readings are returned read-only.
// - Duty cycle and switching frequency readings are returned read-only.
// - Protocol revision reads fixed 22h.
// - Text registers store bytes and return the last stored value.
// - User feature settings are read-write, loaded from the config strap.
// - Fault alert line is pulled low while any fault is present.
`timescale 1ns/10ps
module pms_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic fault_alert_line_o,
  output logic fault_alert_line_oe,
  input wire logic [pms_pkg::WORD_W-1:0] undervoltage_lockout_strap,
  input wire logic [pms_pkg::WORD_W-1:0] output_setpoint_strap,
  input wire logic [pms_pkg::BYTE_W-1:0] config_strap,
  input wire logic [pms_pkg::WORD_W-1:0] vin_meas,
  input wire logic [pms_pkg::WORD_W-1:0] vout_meas,
  input wire logic [pms_pkg::WORD_W-1:0] iout_meas,
  input wire logic [pms_pkg::WORD_W-1:0] temp_int_meas,
  input wire logic [pms_pkg::WORD_W-1:0] temp_ext_meas,
  input wire logic [pms_pkg::WORD_W-1:0] duty_meas,
  input wire logic [pms_pkg::WORD_W-1:0] freq_meas,
  input wire logic [pms_pkg::BYTE_W-1:0] vout_evt,
  input wire logic [pms_pkg::BYTE_W-1:0] iout_evt,
  input wire logic [pms_pkg::BYTE_W-1:0] input_evt,
  input wire logic [pms_pkg::BYTE_W-1:0] temp_evt,
  input wire logic [pms_pkg::BYTE_W-1:0] vendor_evt,
  input wire logic [pms_pkg::BYTE_W-1:0] mem_logic_evt,
  input wire logic fault_clear,
  output logic [pms_pkg::WORD_W-1:0] input_undervoltage_fault_threshold,
  output logic [pms_pkg::BYTE_W-1:0] input_undervoltage_fault_action,
  output logic [pms_pkg::WORD_W-1:0] power_good_threshold,
  output logic [pms_pkg::WORD_W-1:0] turn_on_wait_time,
  output logic [pms_pkg::WORD_W-1:0] output_ramp_up_time,
  output logic [pms_pkg::WORD_W-1:0] turn_off_wait_time,
  output logic [pms_pkg::WORD_W-1:0] output_ramp_down_time,
  output logic [pms_pkg::BYTE_W-1:0] user_feature_settings
);
  import pms_pkg::*;

  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_CMD, LK_WDAT, LK_RDAT
  } pms_link_e;

  // Byte length of a writable command; zero for read-only or unmapped.
  function automatic logic [1:0] wr_len(input logic [7:0] c);
    case (c)
      CMD_UV_LIMIT, CMD_PG_THRESH, CMD_TON_WAIT, CMD_TON_RAMP,
      CMD_TOFF_WAIT, CMD_TOFF_RAMP: wr_len = 2'h2;
      CMD_UV_ACTION, CMD_MAKER_STR, CMD_UREV_STR, CMD_ULOC_STR,
      CMD_UDATE_STR, CMD_SERIAL_STR, CMD_SCRATCH_STR,
      CMD_USER_CFG: wr_len = 2'h1;
      default: wr_len = 2'h0;
    endcase
  endfunction

  // Slot of a text register, or STR_N when the command is not text.
  function automatic logic [2:0] str_slot(input logic [7:0] c);
    case (c)
      CMD_MAKER_STR: str_slot = 3'h0;
      CMD_UREV_STR: str_slot = 3'h1;
      CMD_ULOC_STR: str_slot = 3'h2;
      CMD_UDATE_STR: str_slot = 3'h3;
      CMD_SERIAL_STR: str_slot = 3'h4;
      CMD_SCRATCH_STR: str_slot = 3'h5;
      default: str_slot = 3'(STR_N);
    endcase
  endfunction

  // ---------------- Link domain ----------------
  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  logic ack_s1_q, ack_s2_q, ack_s3_q;
  pms_link_e lst_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, tx_q, cmd_q;
  logic [15:0] wdat_q, rd_l_q, rdata_q;
  logic [1:0] wlen_q, ridx_q;
  logic rw_q, nack_q, req_wr_q, req_tgl_q, sda_oe_q, ack_tgl_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] next_tx;

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  assign next_tx = (ridx_q == 2'h0) ? rd_l_q[7:0] :
                   (ridx_q == 2'h1) ? rd_l_q[15:8] : PAST_END_BYTE;
  assign sda_oe = sda_oe_q;
  assign sda_o = 1'b0;

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // Read data is held still by the core once its toggle moves.
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      rd_l_q <= RST_WORD;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      if (ack_s2_q != ack_s3_q) begin
        rd_l_q <= rdata_q;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lst_q <= LK_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_q <= 8'h00;
      wdat_q <= RST_WORD;
      wlen_q <= 2'h0;
      ridx_q <= 2'h0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      req_wr_q <= 1'b0;
      req_tgl_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (bus_start) begin
      lst_q <= LK_ADDR;
      cnt_q <= 4'h0;
      ridx_q <= 2'h0;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      // A write is handed over only once the frame ends.
      if (lst_q == LK_WDAT && wlen_q != 2'h0) begin
        req_wr_q <= 1'b1;
        req_tgl_q <= ~req_tgl_q;
      end
      lst_q <= LK_IDLE;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (lst_q != LK_IDLE) begin
      if (scl_rise && cnt_q != BIT_END) begin
        if (cnt_q < BIT_ACK) begin
          sh_q <= {sh_q[6:0], sda_s2_q};
        end else begin
          nack_q <= sda_s2_q;
        end
        cnt_q <= cnt_q + 4'h1;
      end
      if (scl_fall) begin
        if (cnt_q == BIT_ACK) begin
          case (lst_q)
            LK_ADDR: begin
              if (sh_q[7:1] == SLAVE_ADDR) begin
                sda_oe_q <= 1'b1;
                rw_q <= sh_q[0];
              end else begin
                lst_q <= LK_IDLE;
              end
            end
            LK_CMD: begin
              cmd_q <= sh_q;
              wlen_q <= 2'h0;
              req_wr_q <= 1'b0;
              req_tgl_q <= ~req_tgl_q;
              sda_oe_q <= 1'b1;
            end
            LK_WDAT: begin
              if (wlen_q == 2'h0) begin
                wdat_q[7:0] <= sh_q;
              end else if (wlen_q == 2'h1) begin
                wdat_q[15:8] <= sh_q;
              end
              if (wlen_q != WLEN_MAX) begin
                wlen_q <= wlen_q + 2'h1;
              end
              sda_oe_q <= 1'b1;
            end
            default: sda_oe_q <= 1'b0;
          endcase
        end else if (cnt_q == BIT_END) begin
          cnt_q <= 4'h0;
          if ((lst_q == LK_ADDR && rw_q) ||
              (lst_q == LK_RDAT && !nack_q)) begin
            lst_q <= LK_RDAT;
            tx_q <= next_tx;
            sda_oe_q <= ~next_tx[7];
            if (ridx_q != WLEN_MAX) begin
              ridx_q <= ridx_q + 2'h1;
            end
          end else begin
            sda_oe_q <= 1'b0;
            case (lst_q)
              LK_ADDR: lst_q <= LK_CMD;
              LK_CMD: lst_q <= LK_WDAT;
              LK_RDAT: lst_q <= LK_IDLE;
              default: lst_q <= lst_q;
            endcase
          end
        end else if (lst_q == LK_RDAT && cnt_q != 4'h0) begin
          sda_oe_q <= ~tx_q[3'(4'h7 - cnt_q)];
        end
      end
    end
  end

  // ---------------- Core domain ----------------
  logic req_s1_q, req_s2_q, req_s3_q;
  logic [15:0] rd_mux, word_q;
  logic [15:0] uv_s1_q, uv_s2_q, output_setpoint_strap_s1_q, output_setpoint_strap_s2_q;
  logic [7:0] cfg_s1_q, cfg_s2_q;
  logic [1:0] ld_cnt_q;
  logic strap_load, req_evt, wr_evt, wr_ok, wr_ro, wr_badlen, rd_unmapped;
  logic rd_hit;
  logic [15:0] uvlim_q, pg_q, ton_w_q, ton_r_q, toff_w_q, toff_r_q;
  logic [7:0] uvact_q, ucfg_q, cml_set;
  logic [7:0] str_q [STR_N];
  logic [7:0] vout_f_q, iout_f_q, in_f_q, temp_f_q, cml_f_q, vend_f_q;
  logic alert_oe_q;

  assign req_evt = req_s2_q ^ req_s3_q;
  assign wr_evt = req_evt & req_wr_q;
  assign wr_ok = wr_evt && wr_len(cmd_q) != 2'h0 && wr_len(cmd_q) == wlen_q;
  assign wr_ro = wr_evt && wr_len(cmd_q) == 2'h0;
  assign wr_badlen = wr_evt && wr_len(cmd_q) != 2'h0 && !wr_ok;
  // Decoded miss, not the read value: a stored ffffh is a valid register.
  assign rd_unmapped = req_evt && !req_wr_q && !rd_hit;
  assign strap_load = ld_cnt_q == STRAP_LOAD_CNT;
  assign cml_set = (8'(wr_ro | rd_unmapped) << CML_BAD_CMD_BIT) |
                   (8'(wr_badlen) << CML_BAD_DATA_BIT) | mem_logic_evt;

  assign input_undervoltage_fault_threshold = uvlim_q;
  assign input_undervoltage_fault_action = uvact_q;
  assign power_good_threshold = pg_q;
  assign turn_on_wait_time = ton_w_q;
  assign output_ramp_up_time = ton_r_q;
  assign turn_off_wait_time = toff_w_q;
  assign output_ramp_down_time = toff_r_q;
  assign user_feature_settings = ucfg_q;
  assign fault_alert_line_oe = alert_oe_q;
  assign fault_alert_line_o = 1'b0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      uv_s1_q <= RST_WORD;
      uv_s2_q <= RST_WORD;
      output_setpoint_strap_s1_q <= RST_WORD;
      output_setpoint_strap_s2_q <= RST_WORD;
      cfg_s1_q <= RST_FLAGS;
      cfg_s2_q <= RST_FLAGS;
      ld_cnt_q <= 2'h0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      uv_s1_q <= undervoltage_lockout_strap;
      uv_s2_q <= uv_s1_q;
      output_setpoint_strap_s1_q <= output_setpoint_strap;
      output_setpoint_strap_s2_q <= output_setpoint_strap_s1_q;
      cfg_s1_q <= config_strap;
      cfg_s2_q <= cfg_s1_q;
      if (ld_cnt_q != WLEN_MAX) begin
        ld_cnt_q <= ld_cnt_q + 2'h1;
      end
    end
  end

  // Straps are caught once the synchronisers have filled after release.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      uvlim_q <= RST_WORD;
      pg_q <= RST_WORD;
      ucfg_q <= RST_FLAGS;
      uvact_q <= RST_UV_ACTION;
      ton_w_q <= RST_TIMING;
      ton_r_q <= RST_TIMING;
      toff_w_q <= RST_TIMING;
      toff_r_q <= RST_TIMING;
    end else if (strap_load) begin
      uvlim_q <= uv_s2_q;
      pg_q <= 16'((32'(output_setpoint_strap_s2_q) * PG_NUM) / PG_DEN);
      ucfg_q <= cfg_s2_q;
    end else if (wr_ok) begin
      case (cmd_q)
        CMD_UV_LIMIT: uvlim_q <= wdat_q;
        CMD_UV_ACTION: uvact_q <= wdat_q[7:0];
        CMD_PG_THRESH: pg_q <= wdat_q;
        CMD_TON_WAIT: ton_w_q <= wdat_q;
        CMD_TON_RAMP: ton_r_q <= wdat_q;
        CMD_TOFF_WAIT: toff_w_q <= wdat_q;
        CMD_TOFF_RAMP: toff_r_q <= wdat_q;
        CMD_USER_CFG: ucfg_q <= wdat_q[7:0];
        default: ucfg_q <= ucfg_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STR_N; i++) begin
        str_q[i] <= 8'h00;
      end
    end else if (wr_ok && str_slot(cmd_q) != 3'(STR_N)) begin
      str_q[str_slot(cmd_q)] <= wdat_q[7:0];
    end
  end

  // Flags are sticky; an event in the clearing cycle still lands.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vout_f_q <= RST_FLAGS;
      iout_f_q <= RST_FLAGS;
      in_f_q <= RST_FLAGS;
      temp_f_q <= RST_FLAGS;
      cml_f_q <= RST_FLAGS;
      vend_f_q <= RST_FLAGS;
    end else begin
      vout_f_q <= (fault_clear ? RST_FLAGS : vout_f_q) | vout_evt;
      iout_f_q <= (fault_clear ? RST_FLAGS : iout_f_q) | iout_evt;
      in_f_q <= (fault_clear ? RST_FLAGS : in_f_q) | input_evt;
      temp_f_q <= (fault_clear ? RST_FLAGS : temp_f_q) | temp_evt;
      cml_f_q <= (fault_clear ? RST_FLAGS : cml_f_q) | cml_set;
      vend_f_q <= (fault_clear ? RST_FLAGS : vend_f_q) |
                  vendor_evt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_q <= RST_WORD;
      alert_oe_q <= 1'b0;
    end else begin
      // Widen before shifting so no flag bit is shifted out of one bit.
      word_q <= (16'(|cml_f_q) << SUM_CML_BIT) |
                (16'(|temp_f_q) << SUM_TEMP_BIT) |
                (16'(|in_f_q) << SUM_INPUT_BIT) |
                (16'(|iout_f_q) << SUM_IOUT_BIT) |
                (16'(|vout_f_q) << SUM_VOUT_BIT) |
                (16'(|vend_f_q) << SUM_VENDOR_BIT) |
                (16'(|in_f_q) << SUM_INPUTW_BIT) |
                (16'(|iout_f_q) << SUM_IOUTW_BIT) |
                (16'(|vout_f_q) << SUM_VOUTW_BIT);
      alert_oe_q <= |word_q;
    end
  end

  always_comb begin
    rd_mux = UNMAPPED_READ;
    rd_hit = 1'b1;
    case (cmd_q)
      CMD_UV_LIMIT: rd_mux = uvlim_q;
      CMD_UV_ACTION: rd_mux = {8'h00, uvact_q};
      CMD_PG_THRESH: rd_mux = pg_q;
      CMD_TON_WAIT: rd_mux = ton_w_q;
      CMD_TON_RAMP: rd_mux = ton_r_q;
      CMD_TOFF_WAIT: rd_mux = toff_w_q;
      CMD_TOFF_RAMP: rd_mux = toff_r_q;
      CMD_SUM_LOW: rd_mux = {8'h00, word_q[7:0]};
      CMD_SUM_FULL: rd_mux = word_q;
      CMD_VOUT_FLAGS: rd_mux = {8'h00, vout_f_q};
      CMD_IOUT_FLAGS: rd_mux = {8'h00, iout_f_q};
      CMD_INPUT_FLAGS: rd_mux = {8'h00, in_f_q};
      CMD_TEMP_FLAGS: rd_mux = {8'h00, temp_f_q};
      CMD_CML_FLAGS: rd_mux = {8'h00, cml_f_q};
      CMD_VENDOR_FLAGS: rd_mux = {8'h00, vend_f_q};
      CMD_VIN_READ: rd_mux = vin_meas;
      CMD_VOUT_READ: rd_mux = vout_meas;
      CMD_IOUT_READ: rd_mux = iout_meas;
      CMD_TINT_READ: rd_mux = temp_int_meas;
      CMD_TEXT_READ: rd_mux = temp_ext_meas;
      CMD_DUTY_READ: rd_mux = duty_meas;
      CMD_FREQ_READ: rd_mux = freq_meas;
      CMD_PROTO_REV: rd_mux = {8'h00, PROTO_REV_VALUE};
      CMD_USER_CFG: rd_mux = {8'h00, ucfg_q};
      default: begin
        if (str_slot(cmd_q) != 3'(STR_N)) begin
          rd_mux = {8'h00, str_q[str_slot(cmd_q)]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // Readings are snapped when the command byte lands, so a read returns
  // the value as it stood then, not at the later repeated start.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= RST_WORD;
      ack_tgl_q <= 1'b0;
    end else if (req_evt && !req_wr_q) begin
      rdata_q <= rd_mux;
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

  // ---------------- Checks ----------------
  sequence s_lookup(logic [7:0] c);
    req_evt && !req_wr_q && cmd_q == c;
  endsequence
  sequence s_write(logic [7:0] c);
    wr_evt && cmd_q == c;
  endsequence

  property p_byte_mirror;
    @(posedge clk) disable iff (!rst_b)
      s_lookup(CMD_SUM_LOW) |=> rdata_q == {8'h00, $past(word_q[7:0])};
  endproperty
  a_byte_mirror: assert property (p_byte_mirror)
    else $error("summary byte differs from word low byte");

  property p_word_quiet;
    @(posedge clk) disable iff (!rst_b)
      (vout_f_q | iout_f_q | in_f_q | temp_f_q | cml_f_q | vend_f_q) == 8'h00
      |=> word_q == 16'h0000;
  endproperty
  a_word_quiet: assert property (p_word_quiet)
    else $error("summary word set without any fault");

  property p_alert;
    @(posedge clk) disable iff (!rst_b)
      $rose(|(vout_evt | iout_evt | input_evt | temp_evt | vendor_evt))
      |-> ##[1:3] alert_oe_q;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert line not pulled after a fault");

  property p_revision;
    @(posedge clk) disable iff (!rst_b)
      s_lookup(CMD_PROTO_REV) |=> rdata_q == 16'h0022
      ##1 ack_tgl_q == $past(ack_tgl_q);
  endproperty
  a_revision: assert property (p_revision)
    else $error("protocol revision not returned");

  property p_ro_write;
    @(posedge clk) disable iff (!rst_b)
      s_write(CMD_SUM_LOW) |=> cml_f_q[7] && rdata_q == $past(rdata_q);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write to read-only command not flagged");

  property p_ton_write;
    @(posedge clk) disable iff (!rst_b)
      s_write(CMD_TON_WAIT) ##0 (wlen_q == 2'h2 && !strap_load)
      |=> ton_w_q == $past(wdat_q);
  endproperty
  a_ton_write: assert property (p_ton_write)
    else $error("turn-on wait not written");

  property p_action_reset;
    @(posedge clk) $rose(rst_b) |-> uvact_q == 8'hbf && toff_r_q == 16'hca80;
  endproperty
  a_action_reset: assert property (p_action_reset)
    else $error("fault action or ramp-down reset value wrong");

  property p_strap;
    @(posedge clk) disable iff (!rst_b)
      strap_load |=> uvlim_q == $past(uv_s2_q) ##1 !strap_load;
  endproperty
  a_strap: assert property (p_strap)
    else $error("threshold not loaded from strap");

  property p_sticky;
    @(posedge clk) disable iff (!rst_b)
      temp_evt[0] |=> temp_f_q[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("temperature event lost");

  property p_addr_ack;
    @(posedge link_clk) disable iff (!rst_b)
      lst_q == LK_ADDR && scl_fall && cnt_q == 4'h8 && sh_q[7:1] == SLAVE_ADDR
      |=> sda_oe_q;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
endmodule

// ---- tb/pms_host.sv ----
// Host controller model that drives the two-wire management link.
`timescale 1ns/10ps
module pms_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_dn
);
  initial begin
    scl = 1'b1;
    sda_dn = 1'b0;
  end
  // Each phase spans many link samples so the device never misses an edge.
  task automatic tick();
    repeat (20) @(posedge clk);
  endtask
  task automatic xbit(input logic b, output logic r);
    sda_dn <= !b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda;
    scl <= 1'b0;
    tick();
  endtask
  task automatic start();
    sda_dn <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_dn <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_dn <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_dn <= 1'b0;
    tick();
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(a, r);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d,
                    input logic two);
    logic [7:0] q;
    start();
    xbyte(8'h40, 1'b1, q);
    xbyte(c, 1'b1, q);
    xbyte(d[7:0], 1'b1, q);
    if (two) begin
      xbyte(d[15:8], 1'b1, q);
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    logic [7:0] q;
    start();
    xbyte(8'h40, 1'b1, q);
    xbyte(c, 1'b1, q);
    start();
    xbyte(8'h41, 1'b1, q);
    xbyte(8'hff, 1'b0, v[7:0]);
    xbyte(8'hff, 1'b1, v[15:8]);
    stop();
    repeat (500) @(posedge clk);
  endtask
endmodule

// ---- tb/pms_regs_tb.sv ----
// Self-checking bench for the status and sequencing register bank.
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  err_total++; $display("Error %s exp %h got %h", n, e, s); end end
module pms_regs_tb;
  logic clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, clr = 1'b0;
  logic scl, sda_dn, sda_oe, al_oe, sda_lo, al_lo;
  logic [7:0] evt = 8'h00, act, ucfg, cfs = 8'h4b;
  logic [15:0] m = 16'h1200, uvs = 16'hd311, vss = 16'h0190, v;
  logic [15:0] thr, pg, t0, t1, t2, t3;
  logic [7:0] tc[4] = '{8'h60, 8'h61, 8'h64, 8'h65};
  logic [7:0] mc[7] = '{8'h88, 8'h8b, 8'h8c, 8'h8d, 8'h8f, 8'h94, 8'h95};
  int err_total = 0, comparisons = 0;
  wire sda = !(sda_dn | sda_oe);
  pms_host i_pms_host (.clk(clk), .sda(sda), .scl(scl), .sda_dn(sda_dn));
  pms_regs i_pms_regs (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_lo), .sda_oe(sda_oe),
    .fault_alert_line_o(al_lo), .fault_alert_line_oe(al_oe),
    .undervoltage_lockout_strap(uvs), .output_setpoint_strap(vss),
    .config_strap(cfs), .vin_meas(m), .vout_meas(m + 16'h1),
    .iout_meas(m + 16'h2), .temp_int_meas(m + 16'h3),
    .temp_ext_meas(m + 16'h4), .duty_meas(m + 16'h5),
    .freq_meas(m + 16'h6), .vout_evt(8'h00), .iout_evt(8'h00),
    .input_evt(8'h00), .temp_evt(evt), .vendor_evt(8'h00),
    .mem_logic_evt(8'h00), .fault_clear(clr),
    .input_undervoltage_fault_threshold(thr),
    .input_undervoltage_fault_action(act), .power_good_threshold(pg),
    .turn_on_wait_time(t0), .output_ramp_up_time(t1),
    .turn_off_wait_time(t2), .output_ramp_down_time(t3),
    .user_feature_settings(ucfg));
  initial forever #20 clk = ~clk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  task automatic summarize();
    $display("Errors %0d of %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("act", 8'hbf, act)
    `CHK("ton", 32'hca80ca80, {t0, t1})
    `CHK("toff", 32'hca80ca80, {t2, t3})
    `CHK("od", 2'b00, {sda_lo, al_lo})
    `CHK("uv", uvs, thr)
    `CHK("pg", 16'h0168, pg)
    `CHK("cfg", cfs, ucfg)
    for (int i = 0; i < 4; i++) begin
      i_pms_host.wr(tc[i], 16'h1234 + 16'(i), 1'b1);
      i_pms_host.rd(tc[i], v);
      `CHK("seq", 16'h1234 + 16'(i), v)
    end
    `CHK("ton", 16'h1234, t0)
    i_pms_host.wr(8'h5a, 16'h003c, 1'b0);
    `CHK("act", 8'h3c, act)
    i_pms_host.wr(8'hd1, 16'h00a5, 1'b0);
    i_pms_host.wr(8'h5e, 16'h0abc, 1'b1);
    `CHK("cfg", 8'ha5, ucfg)
    `CHK("pg", 16'h0abc, pg)
    for (int i = 0; i < 7; i++) begin
      i_pms_host.rd(mc[i], v);
      `CHK("meas", m + 16'(i), v)
    end
    i_pms_host.rd(8'h98, v);
    `CHK("rev", 16'h0022, v)
    i_pms_host.rd(8'h80, v);
    `CHK("vend", 16'h0000, v)
    i_pms_host.wr(8'h9c, 16'h005a, 1'b0);
    i_pms_host.rd(8'h9c, v);
    `CHK("str", 16'h005a, v)
    i_pms_host.wr(8'h78, 16'h0055, 1'b0);
    i_pms_host.wr(8'h59, 16'h0011, 1'b0);
    `CHK("uv", uvs, thr)
    i_pms_host.rd(8'h7e, v);
    `CHK("cml", 16'h00c0, v)
    i_pms_host.rd(8'h78, v);
    `CHK("sum8", 16'h0002, v)
    i_pms_host.rd(8'h79, v);
    `CHK("sum16", 16'h0002, v)
    `CHK("alert", 1'b1, al_oe)
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("alert", 1'b0, al_oe)
    // Event and clear in one cycle: the event must still land.
    evt <= 8'h01;
    clr <= 1'b1;
    @(posedge clk);
    evt <= 8'h00;
    clr <= 1'b0;
    i_pms_host.rd(8'h7d, v);
    `CHK("temp", 16'h0001, v)
    `CHK("alert", 1'b1, al_oe)
    summarize();
  end
endmodule
